// [itsb_irq_time_base.sv]
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - set the external flag on a pin transition matching the chosen edge
// - vector only with global and source enable set and stack not full
// - servicing clears the serviced flag and the global enable
// - external edge select: off, rising, falling or both
// - the pin pull-high choice stays in effect in interrupt use
// - proximity detection sets its flag on the edge chosen by a two-bit field
// - conversion done sets its flag; vectors only when enabled
// - compare A and compare P have separate flags, enables and vectors
// - a low-supply report sets the low-voltage flag
// - end of each data memory write sets the memory flag
// - each time base sets its own flag on divider overflow
// - prescaler clock: system clock, system clock over four, or low-speed clock
// - time base 0 runs while bit 7 is one; period 2^(8+n)
// - unimplemented prescaler and time-base control bits read zero
// - any flag rising wakes the device, enabled or not
// - a set flag stays until serviced or cleared by software
module itsb_irq_time_base (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [itsb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [itsb_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [itsb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [itsb_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        ext_irq_pin,
  input  wire logic                        ext_pin_fn_sel,
  input  wire logic                        ext_port_input,
  input  wire logic                        prox_detect,
  input  wire logic                        conv_done,
  input  wire logic                        cmp_a_match,
  input  wire logic                        cmp_p_match,
  input  wire logic                        low_volt_det,
  input  wire logic                        nvm_write_done,
  input  wire logic                        sub_clk,
  input  wire logic                        stack_full,
  input  wire logic                        svc_ack,
  output logic                             irq,
  output logic [3:0]                       irq_vector,
  output logic                             wake,
  output logic                             ext_pull_enable
);
  import itsb_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = !prev && cur;
    fall = prev && !cur;
    unique case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise || fall;
      EDGE_OFF:  edge_hit = 1'b0;
    endcase
  endfunction

  // overflow when the low 8+n bits are all ones
  function automatic logic tb_wrap(input logic [TB_CNT_W-1:0] cnt, input logic [2:0] sel);
    logic [TB_CNT_W-1:0] m;
    m = TB_CNT_W'((32'd1 << (TB_BASE_EXP + int'(sel))) - 32'd1);
    tb_wrap = ((cnt & m) == m);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (d & m);
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [1:0]          prescaler_src_sel;
  logic [7:0]          time_base_zero_control;
  logic [7:0]          time_base_one_control;
  logic                global_irq_enable;
  logic [1:0]          ext_edge_select;
  logic [1:0]          prox_edge_select;
  logic                prox_sense_on;
  logic                ext_pull_sel;
  logic [NSRC-1:0]     flags;
  logic [NSRC-1:0]     enables;
  logic [NSRC-1:0]     next_flags;
  logic [NSRC-1:0]     set_ev;
  logic [NSRC-1:0]     clr_ev;
  logic [NSRC-1:0]     pending;
  logic [NSRC-1:0]     svc_onehot;
  logic [3:0]          svc_index;
  logic                svc_take;
  logic [2:0]          ext_sync;
  logic [2:0]          prox_sync;
  logic [2:0]          lv_sync;
  logic [2:0]          sub_sync;
  logic                ext_hit;
  logic                prox_hit;
  logic [1:0]          div4_cnt;
  logic                psc_tick;
  logic [TB_CNT_W-1:0] tb0_cnt;
  logic [TB_CNT_W-1:0] tb1_cnt;
  logic                tb0_hit;
  logic                tb1_hit;
  logic                aw_got;
  logic                w_got;
  logic [ADDR_W-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                do_write;
  logic [ADDR_W-1:0]   rd_addr;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic                wr_hit;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // input synchronisers; only stage 1 and 2 are read by logic
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sync  <= 3'h0;
      prox_sync <= 3'h0;
      lv_sync   <= 3'h0;
      sub_sync  <= 3'h0;
    end else begin
      ext_sync  <= {ext_sync[1:0], ext_irq_pin};
      prox_sync <= {prox_sync[1:0], prox_detect};
      lv_sync   <= {lv_sync[1:0], low_volt_det};
      sub_sync  <= {sub_sync[1:0], sub_clk};
    end
  end

  // the pin is only an interrupt input once routed and set as input
  assign ext_hit  = ext_pin_fn_sel && ext_port_input &&
                    edge_hit(ext_edge_select, ext_sync[2], ext_sync[1]);
  assign prox_hit = prox_sense_on && edge_hit(prox_edge_select, prox_sync[2], prox_sync[1]);

  a_ext_off: assert property (ext_edge_select == EDGE_OFF |-> !ext_hit)
    else $error("external edge seen while edge select is off");
  a_ext_flag: assert property (ext_hit |=> flags[SRC_EXT])
    else $error("external edge did not set its flag");
  a_prox_flag: assert property (prox_hit |=> flags[SRC_PROX])
    else $error("proximity edge did not set its flag");

  // ----------------------------------------------------------------
  // prescaler and time bases
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div4_cnt <= 2'h0;
    end else begin
      div4_cnt <= div4_cnt + 2'h1;
    end
  end

  // low-speed clock is counted on its synchronised rising edge
  always_comb begin
    unique case (prescaler_src_sel)
      PSC_SYS:  psc_tick = 1'b1;
      PSC_DIV4: psc_tick = (div4_cnt == DIV4_LAST);
      default:  psc_tick = sub_sync[1] && !sub_sync[2];
    endcase
  end

  a_psc_div4: assert property (prescaler_src_sel == PSC_DIV4 && psc_tick |=> !psc_tick ##1 !psc_tick)
    else $error("divide-by-four prescaler ticked too often");

  assign tb0_hit = time_base_zero_control[TB_RUN_BIT] && psc_tick && tb_wrap(tb0_cnt, time_base_zero_control[2:0]);
  assign tb1_hit = time_base_one_control[TB_RUN_BIT] && psc_tick && tb_wrap(tb1_cnt, time_base_one_control[2:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb0_cnt <= '0;
      tb1_cnt <= '0;
    end else begin
      if (!time_base_zero_control[TB_RUN_BIT]) begin
        tb0_cnt <= '0;
      end else if (psc_tick) begin
        tb0_cnt <= tb0_cnt + TB_CNT_W'(1);
      end
      if (!time_base_one_control[TB_RUN_BIT]) begin
        tb1_cnt <= '0;
      end else if (psc_tick) begin
        tb1_cnt <= tb1_cnt + TB_CNT_W'(1);
      end
    end
  end

  a_tb0_idle: assert property (!time_base_zero_control[TB_RUN_BIT] |=> tb0_cnt == '0)
    else $error("time base 0 counted while stopped");
  a_tb0_period: assert property (tb0_hit && time_base_zero_control[2:0] == 3'h0 |-> tb0_cnt[7:0] == 8'hFF)
    else $error("time base 0 overflow at wrong count");
  a_tb1_flag: assert property (tb1_hit |=> flags[SRC_TICK1])
    else $error("time base 1 overflow did not set its flag");

  // ----------------------------------------------------------------
  // request flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    set_ev             = '0;
    set_ev[SRC_EXT]    = ext_hit;
    set_ev[SRC_PROX]   = prox_hit;
    set_ev[SRC_CONV]   = conv_done;
    set_ev[SRC_CMP_A]  = cmp_a_match;
    set_ev[SRC_CMP_P]  = cmp_p_match;
    set_ev[SRC_LV]     = lv_sync[1] && !lv_sync[2];
    set_ev[SRC_NVM]    = nvm_write_done;
    set_ev[SRC_TICK0]  = tb0_hit;
    set_ev[SRC_TICK1]  = tb1_hit;
    clr_ev = svc_onehot;
    if (do_write && aw_addr == OFF_FLAGS) begin
      clr_ev = clr_ev | NSRC'(merge(32'h0, w_data, w_strb));
    end
    next_flags = (flags & ~clr_ev) | set_ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= RST_SRC;
      wake  <= 1'b0;
    end else begin
      flags <= next_flags;
      wake  <= |(next_flags & ~flags);
    end
  end

  a_wake_rise: assert property ((flags & ~$past(flags)) != '0 |-> wake)
    else $error("flag rose without a wake pulse");
  a_conv_flag: assert property (conv_done |=> flags[SRC_CONV])
    else $error("conversion done did not set its flag");
  a_lv_flag: assert property (lv_sync[1] && !lv_sync[2] |=> flags[SRC_LV])
    else $error("low supply did not set its flag");
  a_flag_hold: assert property (flags[SRC_NVM] && !svc_onehot[SRC_NVM] && !(do_write && aw_addr == OFF_FLAGS)
                                |=> flags[SRC_NVM])
    else $error("memory flag dropped without a clear");

  // ----------------------------------------------------------------
  // arbitration and service
  // ----------------------------------------------------------------
  assign pending  = flags & enables;
  assign svc_take = svc_ack && irq && global_irq_enable && !stack_full;

  // fixed priority: lowest source index first, the rest stay pending
  always_comb begin
    svc_onehot = '0;
    svc_index  = 4'hF;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        svc_index = 4'(i);
      end
    end
    if (svc_take && svc_index != 4'hF) begin
      svc_onehot[svc_index] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq        <= 1'b0;
      irq_vector <= 4'h0;
    end else begin
      irq <= global_irq_enable && !stack_full && (|pending) && !svc_take;
      if (svc_take) begin
        irq_vector <= svc_index;
      end
    end
  end

  a_irq_gate: assert property (irq |-> $past(global_irq_enable) && !$past(stack_full))
    else $error("request raised without global enable or with full stack");
  a_svc_gie: assert property (svc_take |=> !global_irq_enable)
    else $error("service left the global enable set");
  a_svc_prio: assert property (svc_take && pending[SRC_EXT] |=> irq_vector == 4'h0 && !flags[SRC_EXT] || $past(ext_hit))
    else $error("highest priority source not serviced first");

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_hit   = aw_addr inside {OFF_PSC, OFF_TB0, OFF_TB1, OFF_CTRL, OFF_FLAGS, OFF_ENABLE, OFF_STATUS};
  assign rd_hit   = s_axi_araddr inside {OFF_PSC, OFF_TB0, OFF_TB1, OFF_CTRL, OFF_FLAGS, OFF_ENABLE, OFF_STATUS};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescaler_src_sel      <= 2'h0;
      time_base_zero_control <= RST_REG8;
      time_base_one_control  <= RST_REG8;
      ext_edge_select        <= EDGE_OFF;
      prox_edge_select       <= EDGE_OFF;
      prox_sense_on          <= 1'b0;
      ext_pull_sel           <= 1'b0;
      enables                <= RST_SRC;
    end else if (do_write) begin
      unique case (aw_addr)
        OFF_PSC:    prescaler_src_sel      <= 2'(merge(32'(prescaler_src_sel), w_data, w_strb));
        OFF_TB0:    time_base_zero_control <= 8'(merge(32'(time_base_zero_control), w_data, w_strb)) & 8'h87;
        OFF_TB1:    time_base_one_control  <= 8'(merge(32'(time_base_one_control), w_data, w_strb)) & 8'h87;
        OFF_CTRL: begin
          if (w_strb[0]) begin
            ext_edge_select  <= w_data[CTRL_EXT_LO +: 2];
            prox_edge_select <= w_data[CTRL_PROX_LO +: 2];
            prox_sense_on    <= w_data[CTRL_PROX_ON];
            ext_pull_sel     <= w_data[CTRL_PULL];
          end
        end
        OFF_ENABLE: enables <= NSRC'(merge(32'(enables), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // service clears the global enable even against a write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      global_irq_enable <= 1'b0;
    end else if (svc_take) begin
      global_irq_enable <= 1'b0;
    end else if (do_write && aw_addr == OFF_CTRL && w_strb[0]) begin
      global_irq_enable <= w_data[CTRL_GIE];
    end
  end

  // pull-high follows its select whatever the pin is used for
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_pull_enable <= 1'b0;
    end else begin
      ext_pull_enable <= ext_pull_sel;
    end
  end

  always_comb begin
    rd_word = 32'h0;
    unique case (s_axi_araddr)
      OFF_PSC:    rd_word[1:0] = prescaler_src_sel;
      OFF_TB0:    rd_word[7:0] = time_base_zero_control;
      OFF_TB1:    rd_word[7:0] = time_base_one_control;
      OFF_CTRL:   rd_word[6:0] = {ext_pull_sel, prox_sense_on, prox_edge_select, ext_edge_select, global_irq_enable};
      OFF_FLAGS:  rd_word[NSRC-1:0] = flags;
      OFF_ENABLE: rd_word[NSRC-1:0] = enables;
      OFF_STATUS: rd_word[STAT_IRQ:STAT_VEC_LO] = {irq, irq_vector};
      default:    rd_word = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_write) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      rd_addr       <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rd_addr       <= s_axi_araddr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  a_rsv_zero: assert property (s_axi_rvalid && rd_addr == OFF_TB0 |-> s_axi_rdata[6:3] == 4'h0 && s_axi_rdata[31:8] == '0)
    else $error("time base 0 reserved bits read nonzero");

endmodule

`default_nettype wire

// [itsb_pkg.sv]
package itsb_pkg;

  // ----------------------------------------------------------------
  // bus geometry and register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFF_PSC      = 8'h00;
  localparam logic [7:0]  OFF_TB0      = 8'h04;
  localparam logic [7:0]  OFF_TB1      = 8'h08;
  localparam logic [7:0]  OFF_CTRL     = 8'h0C;
  localparam logic [7:0]  OFF_FLAGS    = 8'h10;
  localparam logic [7:0]  OFF_ENABLE   = 8'h14;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          TB_RUN_BIT   = 7;
  localparam int          CTRL_GIE     = 0;
  localparam int          CTRL_EXT_LO  = 1;
  localparam int          CTRL_PROX_LO = 3;
  localparam int          CTRL_PROX_ON = 5;
  localparam int          CTRL_PULL    = 6;
  localparam int          STAT_VEC_LO  = 0;
  localparam int          STAT_IRQ     = 4;

  // ----------------------------------------------------------------
  // sources, in priority order (lowest index wins)
  // ----------------------------------------------------------------
  localparam int          NSRC         = 9;
  localparam int          SRC_EXT      = 0;
  localparam int          SRC_PROX     = 1;
  localparam int          SRC_CONV     = 2;
  localparam int          SRC_CMP_A    = 3;
  localparam int          SRC_CMP_P    = 4;
  localparam int          SRC_LV       = 5;
  localparam int          SRC_NVM      = 6;
  localparam int          SRC_TICK0    = 7;
  localparam int          SRC_TICK1    = 8;

  // ----------------------------------------------------------------
  // encodings, reset values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  EDGE_OFF     = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  localparam logic [1:0]  PSC_SYS      = 2'h0;
  localparam logic [1:0]  PSC_DIV4     = 2'h1;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  localparam int          TB_BASE_EXP  = 8;
  localparam int          TB_CNT_W     = 15;
  localparam logic [7:0]  RST_REG8     = 8'h00;
  localparam logic [8:0]  RST_SRC      = 9'h000;

endpackage

// [itsb_src_model.sv]
`timescale 1ns/100ps
`default_nettype none
module itsb_src_model (
  input  wire logic       clk,
  input  wire logic [3:0] fire,
  input  wire logic       pin_lvl,
  output logic            ext_irq_pin,
  output logic            conv_done,
  output logic            cmp_a_match,
  output logic            cmp_p_match,
  output logic            nvm_write_done
);
  // each fire source pulses for one clock, as the peripherals do; no wider pulse is ever sent; ext_irq_pin follows pin_lvl as a level
  always_ff @(posedge clk) begin
    {conv_done, cmp_a_match, cmp_p_match, nvm_write_done} <= fire;
    ext_irq_pin <= pin_lvl;
  end
endmodule
`default_nettype wire

// [test_itsb_irq_time_base.sv]
`timescale 1ns/100ps
`default_nettype none
module test_itsb_irq_time_base;
  import itsb_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pin_lvl;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wake;
  logic        ext_irq_pin, ext_pin_fn_sel, ext_port_input, prox_detect, conv_done, cmp_a_match, cmp_p_match;
  logic        low_volt_det, nvm_write_done, sub_clk, stack_full, svc_ack, ext_pull_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [3:0]  s_axi_wstrb, irq_vector, fire;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n;
  itsb_irq_time_base uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin, .ext_pin_fn_sel,
    .ext_port_input, .prox_detect, .conv_done, .cmp_a_match, .cmp_p_match, .low_volt_det, .nvm_write_done,
    .sub_clk, .stack_full, .svc_ack, .irq, .irq_vector, .wake, .ext_pull_enable);
  itsb_src_model src (.clk, .fire, .pin_lvl, .ext_irq_pin, .conv_done, .cmp_a_match, .cmp_p_match, .nvm_write_done);
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok) begin
      miscompares++;
      print_verdict();
    end
  endtask
  // ----------------------------------------------------------------
  // bus tasks: ready is looked at before the edge so no race with its flop
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 60 && !hb; n++) begin
      @(negedge clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rd_r = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
    tmo(hb);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hr = 1'b0;
    for (n = 0; n < 60 && !hr; n++) begin
      @(negedge clk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
    tmo(hr);
  endtask
  task automatic t_regs();
    logic [7:0]  adr [3] = '{OFF_PSC, OFF_TB0, OFF_TB1};
    logic [31:0] msk [3] = '{32'h3, 32'h87, 32'h87};
    for (int i = 0; i < 3; i++) begin
      rd(adr[i]);
      `CHK(rd_d, 32'h0)
      wr(adr[i], 32'hFFFFFFFF);
      `CHK(rd_r, RESP_OKAY)
      rd(adr[i]);
      `CHK(rd_d, msk[i])
      wr(adr[i], 32'h0);
    end
    rd(8'h1C);
    `CHK(rd_r, RESP_SLVERR)
    wr(8'h1C, 32'h0);
    `CHK(rd_r, RESP_SLVERR)
    $display("t_regs done");
  endtask
  task automatic t_ext();
    ext_pin_fn_sel <= 1'b1;
    ext_port_input <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CTRL, 32'(32'h40 | (c << 1)));
      for (int e = 0; e < 2; e++) begin
        pin_lvl <= ~pin_lvl;
        repeat (8) @(posedge clk);
        rd(OFF_FLAGS);
        `CHK(rd_d[0], c[e])
        wr(OFF_FLAGS, 32'h1);
      end
    end
    `CHK(ext_pull_enable, 1'b1)
    $display("t_ext done");
  endtask
  task automatic t_src();
    int idx [4] = '{6, 4, 3, 2};
    for (int i = 0; i < 4; i++) begin
      fire <= 4'(1 << i);
      @(posedge clk);
      fire <= 4'h0;
      for (n = 0; n < 8 && wake !== 1'b1; n++) @(negedge clk);
      `CHK(wake, 1'b1)
      @(posedge clk);
      rd(OFF_FLAGS);
      `CHK(rd_d, 32'h1 << idx[i])
      wr(OFF_FLAGS, 32'h1FF);
    end
    low_volt_det <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS);
    `CHK(rd_d, 32'h20)
    wr(OFF_FLAGS, 32'h1FF);
    wr(OFF_CTRL, 32'h28);
    prox_detect <= 1'b1;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS);
    `CHK(rd_d, 32'h2)
    prox_detect <= 1'b0;
    wr(OFF_FLAGS, 32'h1FF);
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS);
    `CHK(rd_d, 32'h0)
    $display("t_src done");
  endtask
  task automatic t_svc();
    wr(OFF_CTRL, 32'h2);
    pin_lvl <= 1'b1;
    fire <= 4'hC;
    @(posedge clk);
    fire <= 4'h0;
    wr(OFF_ENABLE, 32'h1FF);
    stack_full <= 1'b1;
    wr(OFF_CTRL, 32'h3);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    @(posedge clk);
    stack_full <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      for (n = 0; n < 8 && irq !== 1'b1; n++) @(negedge clk);
      `CHK(irq, 1'b1)
      @(posedge clk);
      svc_ack <= 1'b1;
      @(posedge clk);
      svc_ack <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(irq_vector, 4'((k == 0) ? 0 : k + 1))
      rd(OFF_CTRL);
      `CHK(rd_d[0], 1'b0)
      rd(OFF_FLAGS);
      `CHK(rd_d, (k == 0) ? 32'hC : ((k == 1) ? 32'h8 : 32'h0))
      wr(OFF_CTRL, 32'h1);
    end
    $display("t_svc done");
  endtask
  task automatic t_tb();
    wr(OFF_ENABLE, 32'h80);
    wr(OFF_TB0, 32'h81);
    for (n = 0; n < 700 && irq !== 1'b1; n++) @(negedge clk);
    `CHK(n >= 500 && n <= 520, 1'b1)
    @(posedge clk);
    wr(OFF_TB0, 32'h0);
    wr(OFF_FLAGS, 32'h1FF);
    wr(OFF_ENABLE, 32'h100);
    wr(OFF_PSC, 32'h1);
    wr(OFF_TB0, 32'h80);
    wr(OFF_TB1, 32'h80);
    for (n = 0; n < 1300 && irq !== 1'b1; n++) @(negedge clk);
    `CHK(n >= 1016 && n <= 1032, 1'b1)
    @(posedge clk);
    rd(OFF_FLAGS);
    `CHK(rd_d, 32'h180)
    wr(OFF_TB0, 32'h0);
    wr(OFF_TB1, 32'h0);
    $display("t_tb done");
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pin_lvl, ext_pin_fn_sel} = '0;
    {ext_port_input, prox_detect, low_volt_det, sub_clk, stack_full, svc_ack, fire} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_ext();
    t_src();
    t_svc();
    t_tb();
    print_verdict();
  end
endmodule
`default_nettype wire
